/* design/cispc_consts.svh */
// offsets, field positions and reset values of the secure control block
// assumes inclusion by bare name from design files only
`ifndef CISPC_CONSTS_SVH
`define CISPC_CONSTS_SVH

`define CISPC_ADDR_W 12
`define CISPC_CTRL_OFS 12'h000
`define CISPC_BIT_SECURE_EN 0
`define CISPC_BIT_NONSECURE_EN 1
`define CISPC_BIT_CROSS_ACK 2
`define CISPC_BIT_FAST_SEL 3
`define CISPC_BIT_POINT_SEL 4
`define CISPC_RST_SECURE_EN 1'h0
`define CISPC_RST_NONSECURE_EN 1'h0
`define CISPC_RST_CROSS_ACK 1'h0
`define CISPC_RST_FAST_SEL 1'h0
`define CISPC_RST_POINT_SEL 1'h0
`define CISPC_ID_HELD 10'h3fe
`define CISPC_ID_SPURIOUS 10'h3ff
`define CISPC_BPR_W 3

`endif

/* design/cispc_pkg.sv */
// types shared by the secure control block
// assumes nothing beyond a SystemVerilog compiler
package cispc_pkg;

  typedef logic [9:0] cispc_id_t;

  typedef enum logic [1:0] {
    CISPC_ACK_TAKE,
    CISPC_ACK_HELD,
    CISPC_ACK_SPURIOUS
  } cispc_ack_kind_t;

endpackage

/* design/cispc_sync.sv */
// two flip-flop level synchroniser, one chain per bit
// assumes its inputs are asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module cispc_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [WIDTH-1:0] i_async,
  output var logic [WIDTH-1:0] o_sync
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_chain
      logic meta_reg;
      always_ff @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
        begin
          meta_reg <= RESET_VAL[g];
          o_sync[g] <= RESET_VAL[g];
        end
        else
        begin
          meta_reg <= i_async[g];
          o_sync[g] <= meta_reg;
        end
      end
    end
  endgenerate

endmodule // cispc_sync

`default_nettype wire

/* design/cispc_ack.sv */
// acknowledge decision for the top pending interrupt
// assumes the pending logic presents a stable top candidate on i_clk
`timescale 1ns/1ps
`default_nettype none
`include "cispc_consts.svh"

module cispc_ack (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cross_ack,
  input wire logic i_ack_rd,
  input wire logic i_ack_secure,
  input wire logic i_top_valid,
  input wire logic i_top_nonsecure,
  input wire cispc_pkg::cispc_id_t i_top_id,
  output var cispc_pkg::cispc_id_t o_ack_id,
  output var logic o_ack_valid,
  output var logic o_ack_take
);

  cispc_pkg::cispc_ack_kind_t kind;
  wire logic wrong_world;
  wire logic held_ns;

  // a non-secure read never sees a secure candidate
  assign wrong_world = !i_ack_secure && !i_top_nonsecure;
  assign held_ns = i_ack_secure && i_top_nonsecure && !i_cross_ack;
  assign kind = (!i_top_valid || wrong_world) ? cispc_pkg::CISPC_ACK_SPURIOUS :
                held_ns ? cispc_pkg::CISPC_ACK_HELD :
                cispc_pkg::CISPC_ACK_TAKE;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_ack_id <= `CISPC_ID_SPURIOUS;
      o_ack_valid <= 1'b0;
      o_ack_take <= 1'b0;
    end
    else
    begin
      o_ack_valid <= i_ack_rd;
      o_ack_take <= i_ack_rd && (kind == cispc_pkg::CISPC_ACK_TAKE);
      if (i_ack_rd)
      begin
        unique case (kind)
          cispc_pkg::CISPC_ACK_TAKE: o_ack_id <= i_top_id;
          cispc_pkg::CISPC_ACK_HELD: o_ack_id <= `CISPC_ID_HELD;
          cispc_pkg::CISPC_ACK_SPURIOUS: o_ack_id <= `CISPC_ID_SPURIOUS;
        endcase
      end
    end
  end

  ack_held_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ack_rd && i_top_valid && held_ns |=> o_ack_id == 10'h3fe && !o_ack_take && o_ack_valid)
    else $error("held secure read did not return 1022");
  ack_cross_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ack_rd && i_ack_secure && i_top_valid && i_top_nonsecure && i_cross_ack
    |=> o_ack_take && o_ack_id == $past(i_top_id))
    else $error("cross acknowledge did not take the interrupt");
  cv_held_c: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ack_rd && i_top_valid && held_ns);

endmodule // cispc_ack

`default_nettype wire

/* design/cispc_top.sv */
// secure control register, request routing and legacy pass-through
// assumes a same-clock register master and asynchronous legacy request pins
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cispc_consts.svh"

module cispc_top #(
  parameter bit PASSTHRU_EN = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`CISPC_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_access_secure,
  output var logic [31:0] o_rdata,
  input wire logic [`CISPC_BPR_W-1:0] i_secure_bpr,
  input wire logic [`CISPC_BPR_W-1:0] i_nonsecure_bpr,
  output var logic [`CISPC_BPR_W-1:0] o_secure_preempt_bpr,
  output var logic [`CISPC_BPR_W-1:0] o_nonsecure_preempt_bpr,
  input wire logic i_secure_request,
  input wire logic i_nonsecure_request,
  input wire logic i_low_normal_legacy_n,
  input wire logic i_low_fast_legacy_n,
  output var logic o_low_normal_request_pin_n,
  output var logic o_low_fast_request_pin_n,
  input wire logic i_ack_rd,
  input wire logic i_ack_secure,
  input wire logic i_top_valid,
  input wire logic i_top_nonsecure,
  input wire cispc_pkg::cispc_id_t i_top_id,
  output var cispc_pkg::cispc_id_t o_ack_id,
  output var logic o_ack_valid,
  output var logic o_ack_take,
  output var logic o_secure_enable,
  output var logic o_nonsecure_enable
);

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic point_sel_reg;
  logic fast_sel_reg;
  logic cross_ack_reg;
  logic ns_en_reg;
  logic s_en_reg;

  wire logic ctrl_hit;
  wire logic sec_wr;
  wire logic ns_wr;
  wire logic [31:0] sec_view;
  wire logic [31:0] ns_view;
  wire logic [31:0] rdata_next;

  assign ctrl_hit = (i_addr == `CISPC_CTRL_OFS);
  // the access's world picks the bank at the same offset
  assign sec_wr = i_wr && ctrl_hit && i_access_secure;
  assign ns_wr = i_wr && ctrl_hit && !i_access_secure;

  // only bits 4..0 exist; the upper bits are simply absent
  assign sec_view = {27'h000_0000, point_sel_reg, fast_sel_reg, cross_ack_reg,
                     ns_en_reg, s_en_reg};
  assign ns_view = {31'h0000_0000, ns_en_reg};
  // no read, or another offset, gives zero so stale data never stands on the bus
  assign rdata_next = (!i_rd || !ctrl_hit) ? 32'h0000_0000 :
                      i_access_secure ? sec_view : ns_view;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      point_sel_reg <= `CISPC_RST_POINT_SEL;
      fast_sel_reg <= `CISPC_RST_FAST_SEL;
      cross_ack_reg <= `CISPC_RST_CROSS_ACK;
      s_en_reg <= `CISPC_RST_SECURE_EN;
    end
    else if (sec_wr)
    begin
      point_sel_reg <= i_wdata[`CISPC_BIT_POINT_SEL];
      fast_sel_reg <= i_wdata[`CISPC_BIT_FAST_SEL];
      cross_ack_reg <= i_wdata[`CISPC_BIT_CROSS_ACK];
      s_en_reg <= i_wdata[`CISPC_BIT_SECURE_EN];
    end
  end

  // one flop serves both copies: secure bit 1 and non-secure bit 0
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ns_en_reg <= `CISPC_RST_NONSECURE_EN;
    else if (sec_wr)
      ns_en_reg <= i_wdata[`CISPC_BIT_NONSECURE_EN];
    else if (ns_wr)
      ns_en_reg <= i_wdata[0];
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata <= 32'h0000_0000;
      o_secure_enable <= 1'b0;
      o_nonsecure_enable <= 1'b0;
    end
    else
    begin
      o_rdata <= rdata_next;
      o_secure_enable <= s_en_reg;
      o_nonsecure_enable <= ns_en_reg;
    end
  end

  // ---------------------------------------------------------------
  // binary point selection for preemption
  // ---------------------------------------------------------------
  // the secure point is always its own; only the non-secure side is muxed
  wire logic [`CISPC_BPR_W-1:0] ns_bpr_next;

  assign ns_bpr_next = point_sel_reg ? i_secure_bpr : i_nonsecure_bpr;

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_secure_preempt_bpr <= '0;
      o_nonsecure_preempt_bpr <= '0;
    end
    else
    begin
      o_secure_preempt_bpr <= i_secure_bpr;
      o_nonsecure_preempt_bpr <= ns_bpr_next;
    end
  end

  // ---------------------------------------------------------------
  // request routing and pass-through
  // ---------------------------------------------------------------
  logic [1:0] legacy_sync_n;
  wire logic secure_live;
  wire logic nonsecure_live;
  wire logic normal_req;
  wire logic fast_req;
  wire logic normal_drive;
  wire logic fast_drive;
  wire logic normal_pin_next;
  wire logic fast_pin_next;

  // legacy lines idle high; reset value matches so no false request
  cispc_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h3)
  ) u_legacy_sync (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_low_fast_legacy_n, i_low_normal_legacy_n}),
    .o_sync(legacy_sync_n)
  );

  assign secure_live = i_secure_request && s_en_reg;
  assign nonsecure_live = i_nonsecure_request && ns_en_reg;
  // non-secure requests never reach the fast output
  assign normal_req = nonsecure_live || (secure_live && !fast_sel_reg);
  assign fast_req = secure_live && fast_sel_reg;
  assign normal_drive = ns_en_reg || (s_en_reg && !fast_sel_reg);
  assign fast_drive = fast_sel_reg && s_en_reg;

  // without pass-through a disabled output simply idles high
  assign normal_pin_next = (normal_drive || !PASSTHRU_EN) ? !normal_req :
                           legacy_sync_n[0];
  assign fast_pin_next = (fast_drive || !PASSTHRU_EN) ? !fast_req :
                         legacy_sync_n[1];

  // two separate request pins toward the core
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_low_normal_request_pin_n <= 1'b1;
      o_low_fast_request_pin_n <= 1'b1;
    end
    else
    begin
      o_low_normal_request_pin_n <= normal_pin_next;
      o_low_fast_request_pin_n <= fast_pin_next;
    end
  end

  // ---------------------------------------------------------------
  // acknowledge decision
  // ---------------------------------------------------------------
  // cross-acknowledge comes straight from its bit, so a write applies to the next read
  cispc_ack u_ack (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_cross_ack(cross_ack_reg),
    .i_ack_rd(i_ack_rd),
    .i_ack_secure(i_ack_secure),
    .i_top_valid(i_top_valid),
    .i_top_nonsecure(i_top_nonsecure),
    .i_top_id(i_top_id),
    .o_ack_id(o_ack_id),
    .o_ack_valid(o_ack_valid),
    .o_ack_take(o_ack_take)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // all checks share the one clock and stay off while reset is low
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  bpr_shared_a: assert property (point_sel_reg |=>
    o_nonsecure_preempt_bpr == $past(i_secure_bpr))
    else $error("select 1 did not use the secure point");
  bpr_split_a: assert property (!point_sel_reg |=>
    o_nonsecure_preempt_bpr == $past(i_nonsecure_bpr) &&
    o_secure_preempt_bpr == $past(i_secure_bpr))
    else $error("select 0 mixed the points");
  shared_enable_a: assert property (ns_wr ##1 i_rd && ctrl_hit && i_access_secure
    |=> o_rdata[1] == $past(i_wdata[0], 2))
    else $error("enable copies diverged");
  reserved_zero_a: assert property (i_rd |=> o_rdata[31:5] == 27'h000_0000)
    else $error("reserved bits not zero");
  // routing: each request lands only on the output its world picks
  ns_normal_a: assert property (ns_en_reg && i_nonsecure_request
    |=> !o_low_normal_request_pin_n &&
        (!$past(fast_drive && !i_secure_request) || o_low_fast_request_pin_n))
    else $error("non-secure request missed the normal output");
  fast_route_a: assert property (fast_drive && i_secure_request
    |=> !o_low_fast_request_pin_n)
    else $error("secure request missed the fast output");
  normal_route_a: assert property (s_en_reg && !fast_sel_reg && i_secure_request
    |=> !o_low_normal_request_pin_n &&
        o_low_fast_request_pin_n == (PASSTHRU_EN ? $past(legacy_sync_n[1]) : 1'b1))
    else $error("secure request missed the normal output");
  secure_gate_a: assert property (!s_en_reg && !ns_en_reg && PASSTHRU_EN
    |=> o_low_normal_request_pin_n == $past(legacy_sync_n[0]) &&
        o_low_fast_request_pin_n == $past(legacy_sync_n[1]))
    else $error("disabled outputs did not pass through");
  masked_secure_a: assert property (!s_en_reg && ns_en_reg && !i_nonsecure_request
    |=> o_low_normal_request_pin_n)
    else $error("masked secure request was signalled");

  // ---------------------------------------------------------------
  // bank and pass-through checks
  // ---------------------------------------------------------------
  // the banked copies must not leak into each other's bits
  secure_write_a: assert property (sec_wr |=>
    {point_sel_reg, fast_sel_reg, cross_ack_reg, ns_en_reg, s_en_reg} == $past(i_wdata[4:0]))
    else $error("secure write did not load the control bits");
  nonsecure_write_a: assert property (ns_wr |=>
    ns_en_reg == $past(i_wdata[0]) &&
    $stable({point_sel_reg, fast_sel_reg, cross_ack_reg, s_en_reg}))
    else $error("non-secure write touched secure bits");
  ns_view_a: assert property (i_rd && ctrl_hit && !i_access_secure |=>
    o_rdata[31:1] == 31'h0000_0000)
    else $error("non-secure view shows secure bits");
  rdata_idle_a: assert property (!i_rd || !ctrl_hit |=> o_rdata == 32'h0000_0000)
    else $error("read data stood outside a read");

  // each output falls back to its legacy line on its own
  normal_pass_a: assert property (!normal_drive && PASSTHRU_EN
    |=> o_low_normal_request_pin_n == $past(legacy_sync_n[0]))
    else $error("undriven normal output did not pass through");
  fast_pass_a: assert property (!fast_drive && PASSTHRU_EN
    |=> o_low_fast_request_pin_n == $past(legacy_sync_n[1]))
    else $error("undriven fast output did not pass through");
  ns_gated_a: assert property (s_en_reg && !ns_en_reg && !fast_sel_reg && !i_secure_request
    |=> o_low_normal_request_pin_n)
    else $error("disabled non-secure request was signalled");

  // covers: the main paths the bench must reach
  cv_fast_c: cover property (fast_drive && i_secure_request ##1 !o_low_fast_request_pin_n);
  cv_pass_c: cover property (!normal_drive && !legacy_sync_n[0]);
  cv_nswr_c: cover property (ns_wr ##1 i_rd && i_access_secure);
  cv_point_c: cover property (point_sel_reg && i_secure_bpr != i_nonsecure_bpr);

endmodule // cispc_top

`default_nettype wire

/* verification/cispc_core_model.sv */
// processor core model: takes the two active-low request pins
// assumes the pins come straight from the block, with no board pull-ups
`timescale 1ns/1ps
`default_nettype none

module cispc_core_model (
  input wire logic i_clk,
  input wire logic i_low_normal_request_pin_n,
  input wire logic i_low_fast_request_pin_n,
  output var logic o_normal_req,
  output var logic o_fast_req
);
  // ----------------------------------------
  // request sampling
  // ----------------------------------------
  // sampled on the core clock, so this adds one cycle of delay
  always_ff @(posedge i_clk)
  begin
    o_normal_req <= ~i_low_normal_request_pin_n;
    o_fast_req <= ~i_low_fast_request_pin_n;
  end
endmodule // cispc_core_model

`default_nettype wire

/* verification/cispc_top_test.sv */
// self-checking bench for the secure control block
// assumes cispc_top with pass-through, and the core model on its pins
`timescale 1ns/1ps
`default_nettype none

module cispc_top_test;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, sec = 1'b0;
  logic [31:0] rdata;
  logic [2:0] secure_point_select = 3'h0, nbpr = 3'h0, spb, npb;
  logic sreq = 1'b0, nsreq = 1'b0, leg_n = 1'b1, leg_f = 1'b1;
  logic pin_n, pin_f, core_n, core_f, sen_o, nsen_o;
  logic ack_rd = 1'b0, ack_sec = 1'b0, top_v = 1'b0, top_ns = 1'b0;
  cispc_pkg::cispc_id_t top_id = 10'h000;
  cispc_pkg::cispc_id_t ack_id;
  logic ack_v, ack_tk;
  int err_total = 0;
  int checks_done = 0;

  cispc_top #(.PASSTHRU_EN(1'b1)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_access_secure(sec), .o_rdata(rdata),
    .i_secure_bpr(secure_point_select), .i_nonsecure_bpr(nbpr), .o_secure_preempt_bpr(spb),
    .o_nonsecure_preempt_bpr(npb), .i_secure_request(sreq), .i_nonsecure_request(nsreq),
    .i_low_normal_legacy_n(leg_n), .i_low_fast_legacy_n(leg_f),
    .o_low_normal_request_pin_n(pin_n), .o_low_fast_request_pin_n(pin_f),
    .i_ack_rd(ack_rd), .i_ack_secure(ack_sec), .i_top_valid(top_v),
    .i_top_nonsecure(top_ns), .i_top_id(top_id), .o_ack_id(ack_id), .o_ack_valid(ack_v),
    .o_ack_take(ack_tk), .o_secure_enable(sen_o), .o_nonsecure_enable(nsen_o));

  cispc_core_model core (.i_clk(i_clk), .i_low_normal_request_pin_n(pin_n),
    .i_low_fast_request_pin_n(pin_f), .o_normal_req(core_n), .o_fast_req(core_f));

  initial
  begin
    forever #4 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d, input logic s);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    sec <= s;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [11:0] a, input logic s, output logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    sec <= s;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    reg_rd(12'h000, 1'b1, d);
    chk("ctrl reset", d, 32'h0000_0000);
    reg_wr(12'h000, 32'hffff_ffff, 1'b1);
    reg_rd(12'h000, 1'b1, d);
    chk("secure view", d, 32'h0000_001f);
    reg_rd(12'h000, 1'b0, d);
    chk("nonsecure view", d, 32'h0000_0001);
    reg_wr(12'h000, 32'hffff_fffe, 1'b0);
    reg_rd(12'h000, 1'b1, d);
    chk("shared enable", d, 32'h0000_001d);
    reg_wr(12'h004, 32'h0000_0000, 1'b1);
    reg_rd(12'h004, 1'b1, d);
    chk("unmapped read", d, 32'h0000_0000);
    reg_rd(12'h000, 1'b1, d);
    chk("unmapped write", d, 32'h0000_001d);
  endtask

  task automatic t_bpr;
    @(posedge i_clk);
    secure_point_select <= 3'h5;
    nbpr <= 3'h2;
    reg_wr(12'h000, 32'h0000_0000, 1'b1);
    repeat (2) @(posedge i_clk);
    #1;
    chk("secure point", spb, 32'h0000_0005);
    chk("nonsecure point", npb, 32'h0000_0002);
    reg_wr(12'h000, 32'h0000_0010, 1'b1);
    repeat (2) @(posedge i_clk);
    #1;
    chk("shared point", npb, 32'h0000_0005);
  endtask

  // every enable combination against every request and legacy level
  task automatic t_route;
    logic [5:0] v;
    logic f, s, n, en, ef;
    for (int k = 0; k < 64; k++)
    begin
      v = k[5:0];
      {f, s, n} = v[5:3];
      reg_wr(12'h000, {28'h000_0000, f, 1'b0, n, s}, 1'b1);
      @(posedge i_clk);
      sreq <= v[2];
      nsreq <= v[1];
      leg_n <= v[0];
      leg_f <= ~v[0];
      // legacy sync takes two edges, the pin flop one, the core one more
      repeat (5) @(posedge i_clk);
      #1;
      en = (n | (s & ~f)) ? ((v[1] & n) | (v[2] & s & ~f)) : ~v[0];
      ef = (f & s) ? v[2] : v[0];
      chk("normal request", core_n, en);
      chk("fast request", core_f, ef);
      chk("secure enable", sen_o, s);
      chk("nonsecure enable", nsen_o, n);
    end
  endtask

  task automatic ack_case(input logic cx, input logic rs, input logic tv, input logic tn,
                          input logic [9:0] eid, input logic etk);
    reg_wr(12'h000, {29'h0000_0000, cx, 2'b00}, 1'b1);
    @(posedge i_clk);
    ack_rd <= 1'b1;
    ack_sec <= rs;
    top_v <= tv;
    top_ns <= tn;
    top_id <= 10'h05a;
    @(posedge i_clk);
    ack_rd <= 1'b0;
    #1;
    chk("ack valid", ack_v, 32'h0000_0001);
    chk("ack id", ack_id, eid);
    chk("ack take", ack_tk, etk);
  endtask

  task automatic t_ack;
    ack_case(1'b0, 1'b1, 1'b1, 1'b1, 10'h3fe, 1'b0);
    ack_case(1'b1, 1'b1, 1'b1, 1'b1, 10'h05a, 1'b1);
    ack_case(1'b0, 1'b1, 1'b1, 1'b0, 10'h05a, 1'b1);
    ack_case(1'b1, 1'b0, 1'b1, 1'b0, 10'h3ff, 1'b0);
    ack_case(1'b0, 1'b1, 1'b0, 1'b0, 10'h3ff, 1'b0);
  endtask

  // mid-run reset with both pins driven low: all must return to idle
  task automatic t_reset;
    logic [31:0] d;
    reg_wr(12'h000, 32'h0000_001f, 1'b1);
    @(posedge i_clk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    chk("reset normal pin", pin_n, 32'h0000_0001);
    chk("reset fast pin", pin_f, 32'h0000_0001);
    chk("reset secure enable", sen_o, 32'h0000_0000);
    chk("reset nonsecure enable", nsen_o, 32'h0000_0000);
    @(posedge i_clk);
    i_arst_n <= 1'b1;
    reg_rd(12'h000, 1'b1, d);
    chk("ctrl after reset", d, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_regs();
    t_bpr();
    t_route();
    t_ack();
    t_reset();
    test_done();
  end

  // a hang counts as a mismatch
  initial
  begin
    repeat (50000) @(posedge i_clk);
    err_total++;
    test_done();
  end
endmodule // cispc_top_test

`default_nettype wire
